// >>> inc/i2c_slave_pkg.sv
package i2c_slave_pkg;

    localparam int unsigned ADDR_BITS  = 7;
    localparam int unsigned BYTE_BITS  = 8;
    localparam int unsigned CNT_BITS   = 4;
    localparam int unsigned BUF_DEPTH  = 2;

    // Rising clock edges that complete one byte
    localparam logic [3:0]  LAST_BIT   = 4'h8;
    localparam logic [3:0]  CNT_RST    = 4'h0;
    localparam logic [7:0]  SHIFT_RST  = 8'h00;

    // Wait point select encodings
    localparam logic        WAIT_AFTER8 = 1'b0;
    localparam logic        WAIT_AFTER9 = 1'b1;

    // Direction bit encodings
    localparam logic        DIR_WRITE  = 1'b0;
    localparam logic        DIR_READ   = 1'b1;

    // Lines are only ever pulled low
    localparam logic        LINE_LOW   = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_ADDR_HOLD,
        ST_DATA,
        ST_WAIT8,
        ST_DATA_ACK,
        ST_WAIT9,
        ST_IGNORE
    } slave_state_t;

    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } rx_word_t;

    typedef struct packed {
        logic addr_match;
        logic xfer_end;
        logic stop;
    } bus_event_t;

    typedef struct packed {
        logic start_detected_flag;
        logic stop_detected_flag;
        logic addr_matched;
        logic direction;
    } slave_status_t;

    localparam bus_event_t    EVT_RST    = '0;
    localparam slave_status_t STATUS_RST = '0;

endpackage

// >>> rtl/rx_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module rx_skid_buffer #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    logic [WIDTH-1:0] data_all [DEPTH];
    logic [DEPTH:0]   vld_all;
    logic [DEPTH-1:0] shift_vld;
    logic             pop;
    logic             push;

    assign pop       = vld_all[0] & out_ready;
    assign push      = in_valid & in_ready;
    assign in_ready  = ~vld_all[DEPTH-1];
    assign out_data  = data_all[0];
    assign out_valid = vld_all[0];
    assign vld_all[DEPTH] = 1'b0;

    // Entries shift toward the head on a pop; a push fills the first free slot
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            logic             fill;
            logic             vld_ff;
            logic [WIDTH-1:0] data_ff;
            assign shift_vld[i] = pop ? vld_all[i+1] : vld_all[i];
            assign vld_all[i]   = vld_ff;
            assign data_all[i]  = data_ff;
            if (i == 0) begin : g_head
                assign fill = push & ~shift_vld[0];
            end else begin : g_tail
                assign fill = push & ~shift_vld[i] & shift_vld[i-1];
            end
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    vld_ff  <= 1'b0;
                    data_ff <= '0;
                end else begin
                    vld_ff <= shift_vld[i] | fill;
                    if (fill) begin
                        data_ff <= in_data;
                    end else if (pop && i < DEPTH-1) begin
                        data_ff <= data_all[(i+1) % DEPTH];
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> rtl/i2c_slave_rx.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_rx (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire logic                          serial_clock_line_in,
    output logic                               serial_clock_line_out,
    output logic                               serial_clock_line_oe,
    input  wire logic                          serial_data_line_in,
    output logic                               serial_data_line_out,
    output logic                               serial_data_line_oe,
    input  wire logic [6:0]                    own_address,
    input  wire logic                          wait_point_select,
    input  wire logic                          wait_release,
    output logic                               bus_event_interrupt,
    output i2c_slave_pkg::bus_event_t          bus_event,
    output i2c_slave_pkg::slave_status_t       status,
    output logic [7:0]                         shift_data_register,
    output i2c_slave_pkg::rx_word_t            rx_word,
    output logic                               rx_valid,
    input  wire logic                          rx_ready
);
    import i2c_slave_pkg::*;

    logic          scl_meta_ff;
    logic          scl_sync_ff;
    logic          scl_prev_ff;
    logic          sda_meta_ff;
    logic          sda_sync_ff;
    logic          sda_prev_ff;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_edge;
    logic          stop_edge;
    slave_state_t  state_ff;
    slave_state_t  nxt_state;
    logic [3:0]    cnt_ff;
    logic [7:0]    shift_ff;
    logic          late_ff;
    logic          first_ff;
    logic          addr_hit;
    logic          push;
    logic          buf_ready;
    logic          released;
    logic          scl_oe_ff;
    logic          sda_oe_ff;
    logic          irq_ff;
    bus_event_t    evt_ff;
    slave_status_t status_ff;
    rx_word_t      push_word;

    // Two-stage synchronisers, then edge history
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_meta_ff <= 1'b1;
            scl_sync_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
        end else begin
            scl_meta_ff <= serial_clock_line_in;
            scl_sync_ff <= scl_meta_ff;
            scl_prev_ff <= scl_sync_ff;
            sda_meta_ff <= serial_data_line_in;
            sda_sync_ff <= sda_meta_ff;
            sda_prev_ff <= sda_sync_ff;
        end
    end

    assign scl_rise   = scl_sync_ff & ~scl_prev_ff;
    assign scl_fall   = ~scl_sync_ff & scl_prev_ff;
    assign start_edge = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
    assign stop_edge  = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;
    assign addr_hit   = (shift_ff[7:1] == own_address);
    assign released   = wait_release & buf_ready;
    assign push       = released & ((state_ff == ST_WAIT8) | (state_ff == ST_WAIT9));
    assign push_word  = '{first: first_ff, data: shift_ff};

    always_comb begin
        nxt_state = state_ff;
        if (start_edge) begin
            nxt_state = ST_ADDR;
        end else if (stop_edge) begin
            nxt_state = ST_IDLE;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (scl_fall && cnt_ff == LAST_BIT) begin
                        nxt_state = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        nxt_state = ST_ADDR_HOLD;
                    end
                end
                ST_ADDR_HOLD: begin
                    if (wait_release) begin
                        nxt_state = (status_ff.direction == DIR_READ) ? ST_IGNORE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (scl_fall && cnt_ff == LAST_BIT) begin
                        nxt_state = (wait_point_select == WAIT_AFTER8) ? ST_WAIT8 : ST_DATA_ACK;
                    end
                end
                ST_WAIT8: begin
                    if (released) begin
                        nxt_state = ST_DATA_ACK;
                    end
                end
                ST_DATA_ACK: begin
                    if (scl_fall) begin
                        nxt_state = late_ff ? ST_WAIT9 : ST_DATA;
                    end
                end
                ST_WAIT9: begin
                    if (released) begin
                        nxt_state = ST_DATA;
                    end
                end
                default: nxt_state = state_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_ff   <= CNT_RST;
            shift_ff <= SHIFT_RST;
        end else if (start_edge || (nxt_state != state_ff && (nxt_state == ST_ADDR || nxt_state == ST_DATA))) begin
            cnt_ff <= CNT_RST;
        end else if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_DATA)) begin
            cnt_ff   <= cnt_ff + 4'h1;
            shift_ff <= {shift_ff[6:0], sda_sync_ff};
        end
    end

    // Byte bookkeeping for the buffer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            late_ff  <= 1'b0;
            first_ff <= 1'b0;
        end else begin
            if (state_ff == ST_DATA && nxt_state == ST_DATA_ACK) begin
                late_ff <= 1'b1;
            end else if (nxt_state == ST_WAIT8) begin
                late_ff <= 1'b0;
            end
            if (state_ff == ST_ADDR_HOLD) begin
                first_ff <= 1'b1;
            end else if (push) begin
                first_ff <= 1'b0;
            end
        end
    end

    // Open-drain line drivers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            scl_oe_ff <= (nxt_state == ST_ADDR_HOLD) || (nxt_state == ST_WAIT8) || (nxt_state == ST_WAIT9);
            sda_oe_ff <= (nxt_state == ST_ADDR_ACK) || (nxt_state == ST_DATA_ACK);
        end
    end

    // Event pulse and its cause
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
            evt_ff <= EVT_RST;
        end else begin
            irq_ff <= 1'b0;
            if (state_ff == ST_ADDR_ACK && nxt_state == ST_ADDR_HOLD) begin
                irq_ff <= 1'b1;
                evt_ff <= '{addr_match: 1'b1, xfer_end: 1'b0, stop: 1'b0};
            end else if ((state_ff == ST_DATA && nxt_state == ST_WAIT8) ||
                         (state_ff == ST_DATA_ACK && nxt_state == ST_WAIT9)) begin
                irq_ff <= 1'b1;
                evt_ff <= '{addr_match: 1'b0, xfer_end: 1'b1, stop: 1'b0};
            end else if (stop_edge) begin
                irq_ff <= 1'b1;
                evt_ff <= '{addr_match: 1'b0, xfer_end: 1'b0, stop: 1'b1};
            end
        end
    end

    // Status flags
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_ff <= STATUS_RST;
        end else if (start_edge) begin
            status_ff <= '{start_detected_flag: 1'b1, stop_detected_flag: 1'b0,
                           addr_matched: 1'b0, direction: DIR_WRITE};
        end else if (stop_edge) begin
            status_ff <= '{start_detected_flag: 1'b0, stop_detected_flag: 1'b1,
                           addr_matched: 1'b0, direction: DIR_WRITE};
        end else if (state_ff == ST_ADDR && nxt_state == ST_ADDR_ACK) begin
            status_ff.addr_matched <= 1'b1;
            status_ff.direction    <= shift_ff[0];
        end
    end

    rx_skid_buffer #(
        .WIDTH ($bits(rx_word_t)),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_data   (push_word),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .out_data  (rx_word),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign serial_clock_line_out = LINE_LOW;
    assign serial_data_line_out  = LINE_LOW;
    assign serial_clock_line_oe  = scl_oe_ff;
    assign serial_data_line_oe   = sda_oe_ff;
    assign bus_event_interrupt   = irq_ff;
    assign bus_event             = evt_ff;
    assign status                = status_ff;
    assign shift_data_register   = shift_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_addr_ack: assert property (state_ff == ST_ADDR && !start_edge && !stop_edge && scl_fall
        && cnt_ff == LAST_BIT && addr_hit |=> sda_oe_ff ##0 !scl_oe_ff)
        else $error("matching address not acknowledged");
    chk_no_match: assert property (state_ff == ST_ADDR && !start_edge && !stop_edge && scl_fall
        && cnt_ff == LAST_BIT && !addr_hit |=> !sda_oe_ff [*2] ##0 !irq_ff)
        else $error("mismatched address answered");
    chk_match_event: assert property (state_ff == ST_ADDR_ACK && scl_fall && !start_edge && !stop_edge
        |=> irq_ff && evt_ff.addr_match && scl_oe_ff && !sda_oe_ff)
        else $error("address match event or wait missing");
    chk_wait_eighth: assert property (state_ff == ST_DATA && scl_fall && cnt_ff == LAST_BIT
        && wait_point_select == WAIT_AFTER8 && !start_edge && !stop_edge
        |=> scl_oe_ff && irq_ff && evt_ff.xfer_end && !sda_oe_ff)
        else $error("eighth clock wait missing");
    chk_release_ack: assert property (state_ff == ST_WAIT8 && released && !start_edge && !stop_edge
        |=> !scl_oe_ff && sda_oe_ff)
        else $error("release did not free clock and acknowledge");
    chk_hold_stall: assert property (state_ff == ST_WAIT8 && !released && !start_edge && !stop_edge
        |=> scl_oe_ff && $stable(shift_ff))
        else $error("clock freed without release");
    chk_stop_flag: assert property (stop_edge |=> status_ff.stop_detected_flag && irq_ff
        && evt_ff.stop && !scl_oe_ff)
        else $error("stop not flagged");
    chk_scl_wait: assert property (scl_oe_ff |-> state_ff == ST_ADDR_HOLD || state_ff == ST_WAIT8
        || state_ff == ST_WAIT9)
        else $error("clock held outside wait");
    chk_msb_first: assert property (scl_rise && state_ff == ST_DATA && !start_edge && !stop_edge
        |=> shift_ff[0] == $past(sda_sync_ff) && shift_ff[7:1] == $past(shift_ff[6:0]))
        else $error("bit not shifted in msb first");

endmodule

`default_nettype wire

// >>> bench/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    input  wire logic ref_clk,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic scl_oe,
    output var  logic sda_oe
);
    int unsigned stalls = 0;

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Release the clock, wait out any hold by the device, then keep it high
    task automatic rise_scl(output logic sda_seen);
        int guard;
        guard = 0;
        scl_oe <= 1'b0;
        tick(1);
        while (scl_in !== 1'b1 && guard < 4000) begin
            guard++;
            tick(1);
        end
        if (guard > 0)
            stalls++;
        sda_seen = sda_in;
        tick(8);
    endtask

    task automatic start();
        sda_oe <= 1'b1;
        tick(8);
        scl_oe <= 1'b1;
        tick(4);
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            sda_oe <= ~b[i];
            tick(4);
            rise_scl(seen);
            scl_oe <= 1'b1;
            tick(4);
        end
        sda_oe <= 1'b0;
        tick(4);
        rise_scl(seen);
        ack = (seen === 1'b0);
        scl_oe <= 1'b1;
        tick(8);
    endtask

    task automatic stop();
        logic seen;
        sda_oe <= 1'b1;
        tick(4);
        rise_scl(seen);
        sda_oe <= 1'b0;
        tick(8);
    endtask
endmodule

`default_nettype wire

// >>> bench/i2c_slave_addr_and_receive_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_addr_and_receive_tb_top;
    import i2c_slave_pkg::*;

    logic          ref_clk           = 1'b0;
    logic          rst_n             = 1'b0;
    logic [6:0]    own_address       = 7'h00;
    logic          wait_point_select = 1'b0;
    logic          wait_release      = 1'b0;
    logic          rx_ready          = 1'b0;
    logic          s_scl_oe;
    logic          s_sda_oe;
    logic          m_scl_oe;
    logic          m_sda_oe;
    logic          s_scl_out;
    logic          s_sda_out;
    logic [7:0]    shift_seen;
    wire logic     scl;
    wire logic     sda;
    logic          irq;
    logic          rx_valid;
    bus_event_t    bus_event;
    slave_status_t status;
    rx_word_t      rx_word;
    rx_word_t      exp_q[$];
    realtime       stall_end         = 0;
    int            n_errors          = 0;
    int            compares          = 0;
    int            n_irq             = 0;

    always #2.5 ref_clk = ~ref_clk;

    // Open-drain wires with pull-ups
    assign scl = !(m_scl_oe === 1'b1) && !(s_scl_oe === 1'b1 && s_scl_out === 1'b0);
    assign sda = !(m_sda_oe === 1'b1) && !(s_sda_oe === 1'b1 && s_sda_out === 1'b0);

    i2c_slave_rx u_i2c_slave_rx (
        .ref_clk               (ref_clk),
        .rst_n                 (rst_n),
        .serial_clock_line_in  (scl),
        .serial_clock_line_out (s_scl_out),
        .serial_clock_line_oe  (s_scl_oe),
        .serial_data_line_in   (sda),
        .serial_data_line_out  (s_sda_out),
        .serial_data_line_oe   (s_sda_oe),
        .own_address           (own_address),
        .wait_point_select     (wait_point_select),
        .wait_release          (wait_release),
        .bus_event_interrupt   (irq),
        .bus_event             (bus_event),
        .status                (status),
        .shift_data_register   (shift_seen),
        .rx_word               (rx_word),
        .rx_valid              (rx_valid),
        .rx_ready              (rx_ready)
    );

    i2c_master_model u_i2c_master_model (
        .ref_clk (ref_clk),
        .scl_in  (scl),
        .sda_in  (sda),
        .scl_oe  (m_scl_oe),
        .sda_oe  (m_sda_oe)
    );

    task automatic give_verdict();
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bad(input string msg);
        n_errors++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
            bad(msg);
    endtask

    // Consumer, stalled for a while to fill the buffer
    always @(posedge ref_clk) begin
        rx_ready <= ($realtime < stall_end) ? 1'b0 : 1'($urandom % 2);
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0)
                bad("unexpected byte");
            else
                chk(rx_word === exp_q.pop_front(), "received byte");
        end
    end

    always @(posedge ref_clk) begin
        if (irq === 1'b1 && bus_event.stop !== 1'b1)
            n_irq++;
        if (irq === 1'b1 && bus_event.xfer_end === 1'b1)
            chk(s_scl_oe === 1'b1, "clock not held at byte end");
    end

    // Software side: release each wait after a random delay
    initial begin
        int d;
        forever begin
            @(posedge ref_clk);
            if (irq === 1'b1 && bus_event.stop !== 1'b1) begin
                d = 10 + $urandom % 20;
                repeat (d) @(posedge ref_clk);
                wait_release <= 1'b1;
                for (d = 0; d < 5000 && s_scl_oe !== 1'b0; d++)
                    @(posedge ref_clk);
                wait_release <= 1'b0;
            end
        end
    end

    task automatic xfer(input logic [6:0] addr, input logic dir, input int n, input logic sel);
        logic       hit;
        logic       ack;
        logic [7:0] d;
        int         irq0;
        int         st0;
        hit = (addr == own_address);
        wait_point_select <= sel;
        irq0 = n_irq;
        st0 = u_i2c_master_model.stalls;
        u_i2c_master_model.start();
        u_i2c_master_model.send_byte({addr, dir}, ack);
        chk(ack === hit, "address acknowledge");
        chk(status.start_detected_flag === 1'b1, "start flag");
        chk(status.addr_matched === hit && bus_event.addr_match === hit, "match flag");
        chk(status.direction === (hit ? dir : DIR_WRITE), "direction flag");
        chk(shift_seen === {addr, dir}, "address shifter");
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (hit)
                exp_q.push_back({i == 0, d});
            u_i2c_master_model.send_byte(d, ack);
            chk(ack === hit, "data acknowledge");
        end
        chk(n_irq - irq0 == (hit ? n + 1 : 0), "event count");
        u_i2c_master_model.stop();
        repeat (4) @(posedge ref_clk);
        chk(u_i2c_master_model.stalls - st0 == (hit ? n + 1 : 0), "clock holds");
        chk(status.stop_detected_flag === 1'b1 && bus_event.stop === 1'b1, "stop not seen");
    endtask

    initial begin
        void'($urandom(32'h8706));
        @(posedge ref_clk);
        own_address <= 7'($urandom);
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        stall_end = $realtime + 7500.0;
        xfer(own_address, DIR_WRITE, 3, WAIT_AFTER8);
        xfer(own_address ^ 7'h01, DIR_WRITE, 2, WAIT_AFTER8);
        xfer(own_address, DIR_WRITE, 4, WAIT_AFTER9);
        xfer(own_address, DIR_READ, 0, WAIT_AFTER8);
        repeat (300) @(posedge ref_clk);
        chk(exp_q.size() == 0, "bytes missing");
        give_verdict();
    end

    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end
endmodule

`default_nettype wire
